//--- hdl/cf_sig_ctrl.sv
/*
 * card-side control and status signalling of the host interface:
 * ready/interrupt pin, write protect / 16-bit pin, wait, DMA
 * handshake, register select decode, write strobes and the
 * mode-dependent reset and initialization sequence.
 * assumes the card core runs on CLK_SYS, RST_N is the power-up reset,
 * and all *_PIN inputs arrive asynchronously from the host socket.
 */
module cf_sig_ctrl
	import cf_sig_pkg::*;
#(
	parameter int unsigned INIT_CYC = INIT_CYCLES,
	parameter int unsigned PULSE_CYC = IREQ_PULSE_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// mode strap: high PC card modes, low true IDE
	input wire logic MODE_SEL_PIN,
	// host reset pin, polarity by mode
	input wire logic RESET_PIN,
	// register select, active low
	input wire logic REG_N_PIN,
	// write strobe, active low
	input wire logic WE_N_PIN,
	// DMA acknowledge, active low
	input wire logic DMACK_N_PIN,
	// core busy with a transfer
	input wire logic CORE_BUSY,
	// configuration selects I/O mode
	input wire logic CORE_IO_MODE,
	// interrupt raise and service pulses
	input wire logic IRQ_EVENT,
	input wire logic IRQ_SERVICED,
	// level-mode interrupt when high
	input wire logic IRQ_LEVEL_MODE,
	// DMA mode enabled
	input wire logic DMA_ENABLE,
	// core wants a DMA transfer
	input wire logic DMA_REQ,
	// addressed port is 16-bit capable
	input wire logic PORT_16BIT,
	// core expects a word data cycle
	input wire logic WORD_XFER_EXPECT,
	// READY / IREQ_N / INTRQ pin
	output logic RDY_IRQ_PIN,
	// WP / IOIS16_N / IOCS16_N pin
	output logic WP_IOIS16_PIN,
	// WAIT_N / IORDY pin
	output logic WAIT_N_PIN,
	// DMA request pin
	output logic DMARQ_PIN,
	// core held in reset
	output logic CARD_RESET,
	// initialization finished
	output logic INIT_DONE,
	// active mode flags
	output logic MODE_IDE,
	output logic MODE_IO,
	// attribute space selected
	output logic ATTR_SEL,
	// I/O cycle address valid
	output logic IO_CYCLE,
	// one-cycle write strobes
	output logic MEM_WR_STROBE,
	output logic CFG_WR_STROBE,
	// DMA acknowledge to core
	output logic DMA_ACK,
	// interrupt awaiting service
	output logic IRQ_PENDING
);
	// synchronised pins
	logic [SYNC_W-1:0] pins_s;
	logic mode_s;
	logic reset_s;
	logic reg_n_s;
	logic we_n_s;
	logic dmack_n_s;
	// sequencing state
	init_state_e state_reg;
	init_state_e state_next;
	// strap settle counter
	logic [1:0] settle_reg;
	// latched mode: true IDE
	logic ide_reg;
	// reset pin active in the latched mode
	logic reset_act;
	// mode decode while running
	logic mem_mode;
	logic io_mode;
	// timers
	logic init_start;
	logic init_done;
	logic pulse_start;
	logic pulse_busy;
	// interrupt bookkeeping
	logic irq_pend_reg;
	// write strobe edge detect
	logic we_prev_reg;
	logic we_rise;

	// all host pins cross into the clock domain here
	pin_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d({MODE_SEL_PIN, RESET_PIN, REG_N_PIN, WE_N_PIN, DMACK_N_PIN}),
		.q(pins_s)
	);

	assign mode_s = pins_s[4];
	assign reset_s = pins_s[3];
	assign reg_n_s = pins_s[2];
	assign we_n_s = pins_s[1];
	assign dmack_n_s = pins_s[0];

	assign reset_act = ide_reg ? !reset_s : reset_s;

	// mode decode; I/O mode only once configured after init
	assign mem_mode = !ide_reg && !CORE_IO_MODE;
	assign io_mode = !ide_reg && CORE_IO_MODE && (state_reg == ST_RUN);

	// wait for the synchroniser to fill before taking the strap
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			settle_reg <= 2'h0;
		end else if (settle_reg != STRAP_SETTLE) begin
			settle_reg <= settle_reg + 2'h1;
		end
	end

	// strap caught by the third clock after release, held until next power-up
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ide_reg <= 1'h0;
		end else if (state_reg == ST_STRAP && settle_reg == STRAP_SETTLE) begin
			ide_reg <= !mode_s;
		end
	end

	// reset and initialization sequence
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_STRAP: begin
				if (settle_reg == STRAP_SETTLE) begin
					// PC card power-up reset only with pin high
					if (mode_s && !reset_s) begin
						state_next = ST_RUN;
					end else begin
						state_next = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				if (!reset_act) begin
					state_next = ST_INIT;
				end
			end
			ST_INIT: begin
				if (reset_act) begin
					state_next = ST_HOLD;
				end else if (init_done) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (reset_act) begin
					state_next = ST_HOLD;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_STRAP;
		end else begin
			state_reg <= state_next;
		end
	end

	assign init_start = (state_reg == ST_HOLD) && !reset_act;

	cycle_timer #(
		.W(TIMER_W)
	) u_init_tmr (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.start(init_start),
		.count(TIMER_W'(INIT_CYC)),
		.busy(),
		.done(init_done)
	);

	// pulse-mode strobe only on a fresh interrupt
	assign pulse_start = IRQ_EVENT && !irq_pend_reg && io_mode && !IRQ_LEVEL_MODE;

	cycle_timer #(
		.W(TIMER_W)
	) u_pulse_tmr (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.start(pulse_start),
		.count(TIMER_W'(PULSE_CYC)),
		.busy(pulse_busy),
		.done()
	);

	// pending until serviced; a raise in the clear cycle wins
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			irq_pend_reg <= 1'h0;
		end else if (state_reg != ST_RUN) begin
			// a card reset drops any old interrupt
			irq_pend_reg <= 1'h0;
		end else if (IRQ_EVENT) begin
			irq_pend_reg <= 1'h1;
		end else if (IRQ_SERVICED) begin
			irq_pend_reg <= 1'h0;
		end
	end

	// shared ready / interrupt pin
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RDY_IRQ_PIN <= RDY_RST;
		end else if (ide_reg) begin
			RDY_IRQ_PIN <= irq_pend_reg;
		end else if (io_mode) begin
			// low while level pending or pulse running
			RDY_IRQ_PIN <= IRQ_LEVEL_MODE ? !irq_pend_reg : !pulse_busy;
		end else begin
			// ready only after init and when idle
			RDY_IRQ_PIN <= (state_reg == ST_RUN) && !CORE_BUSY;
		end
	end

	// shared write protect / 16-bit pin
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			WP_IOIS16_PIN <= WP_RST;
		end else if (ide_reg) begin
			WP_IOIS16_PIN <= !WORD_XFER_EXPECT;
		end else if (io_mode) begin
			WP_IOIS16_PIN <= !PORT_16BIT;
		end else begin
			WP_IOIS16_PIN <= (state_reg != ST_RUN);
		end
	end

	// wait is never asserted, host cycles never stretched
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			WAIT_N_PIN <= WAIT_N_RST;
		end else begin
			WAIT_N_PIN <= 1'h1;
		end
	end

	// DMA handshake only in IDE with DMA enabled
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			DMARQ_PIN <= 1'h0;
			DMA_ACK <= 1'h0;
		end else begin
			DMARQ_PIN <= ide_reg && DMA_ENABLE && DMA_REQ && (state_reg == ST_RUN);
			DMA_ACK <= ide_reg && DMA_ENABLE && !dmack_n_s && (state_reg == ST_RUN);
		end
	end

	// attribute or common space; I/O address qualifier
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ATTR_SEL <= 1'h0;
			IO_CYCLE <= 1'h0;
		end else begin
			ATTR_SEL <= mem_mode && !reg_n_s;
			IO_CYCLE <= io_mode && !reg_n_s;
		end
	end

	// write strobe ends on its rising edge, where data is taken
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			we_prev_reg <= 1'h1;
		end else begin
			we_prev_reg <= we_n_s;
		end
	end

	assign we_rise = we_n_s && !we_prev_reg;

	// route the strobe by mode; IDE ignores it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			MEM_WR_STROBE <= 1'h0;
			CFG_WR_STROBE <= 1'h0;
		end else begin
			MEM_WR_STROBE <= we_rise && mem_mode && (state_reg == ST_RUN);
			CFG_WR_STROBE <= we_rise && io_mode;
		end
	end

	// status flags to the core
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CARD_RESET <= 1'h1;
			INIT_DONE <= 1'h0;
			MODE_IDE <= 1'h0;
			MODE_IO <= 1'h0;
			IRQ_PENDING <= 1'h0;
		end else begin
			CARD_RESET <= (state_reg == ST_HOLD) || (state_reg == ST_STRAP);
			INIT_DONE <= (state_reg == ST_RUN);
			MODE_IDE <= ide_reg;
			MODE_IO <= io_mode;
			IRQ_PENDING <= irq_pend_reg;
		end
	end

	// checks on the behaviour above
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	// write strobe release seen on the synchronised pin
	sequence we_release;
		!we_n_s ##1 we_n_s;
	endsequence

	// a fresh pulse-mode interrupt
	sequence pulse_raise;
		IRQ_EVENT && !irq_pend_reg && io_mode && !IRQ_LEVEL_MODE;
	endsequence

	chk_ready_busy: assert property (
		mem_mode && state_reg == ST_RUN && CORE_BUSY |=> !RDY_IRQ_PIN
	) else $error("ready high while busy");

	chk_ready_init: assert property (
		!ide_reg && state_reg == ST_INIT |=> !RDY_IRQ_PIN
	) else $error("ready high during initialization");

	chk_no_reset_ready: assert property (
		state_reg == ST_STRAP && settle_reg == STRAP_SETTLE && mode_s && !reset_s
		|=> state_reg == ST_RUN ##1 INIT_DONE
	) else $error("power-up without reset not ready");

	chk_powerup_reset: assert property (
		state_reg == ST_STRAP && settle_reg == STRAP_SETTLE && mode_s && reset_s
		|=> state_reg == ST_HOLD ##1 CARD_RESET
	) else $error("power-up reset not taken");

	chk_ireq_pulse: assert property (
		pulse_raise |=> ##1 !RDY_IRQ_PIN [*2]
	) else $error("interrupt pulse missing");

	chk_ireq_level: assert property (
		io_mode && IRQ_LEVEL_MODE && irq_pend_reg |=> !RDY_IRQ_PIN
	) else $error("level interrupt not held low");

	chk_intrq_high: assert property (
		ide_reg && irq_pend_reg |=> RDY_IRQ_PIN
	) else $error("IDE interrupt not high");

	chk_irq_set_wins: assert property (
		state_reg == ST_RUN && IRQ_EVENT && !reset_act |=> irq_pend_reg ##1 IRQ_PENDING
	) else $error("interrupt lost");

	chk_irq_held: assert property (
		irq_pend_reg && !IRQ_SERVICED && state_reg == ST_RUN && !reset_act
		|=> irq_pend_reg
	) else $error("interrupt dropped before service");

	chk_attr_select: assert property (
		mem_mode && !reg_n_s |=> ATTR_SEL
	) else $error("attribute space not selected");

	chk_dmack_taken: assert property (
		ide_reg && DMA_ENABLE && !dmack_n_s && state_reg == ST_RUN |=> DMA_ACK
	) else $error("DMA acknowledge missed");

	chk_dmack_ignored: assert property (
		!DMA_ENABLE |=> !DMA_ACK && !DMARQ_PIN
	) else $error("DMA handshake while disabled");

	chk_pc_reset_high: assert property (
		(!ide_reg && state_reg != ST_STRAP && reset_s) [*2] |=> CARD_RESET
	) else $error("PC card reset not honoured");

	chk_ide_reset_low: assert property (
		(ide_reg && state_reg != ST_STRAP && !reset_s) [*2] |=> CARD_RESET
	) else $error("IDE reset not honoured");

	chk_wait_never: assert property (
		$past(WAIT_N_PIN) |-> WAIT_N_PIN
	) else $error("wait asserted");

	chk_we_mem: assert property (
		we_release ##0 (mem_mode && state_reg == ST_RUN) |=> MEM_WR_STROBE
	) else $error("memory write not strobed");

	chk_we_io: assert property (
		we_release ##0 io_mode |=> CFG_WR_STROBE && !MEM_WR_STROBE
	) else $error("config write misrouted");

	chk_wp_low: assert property (
		mem_mode && state_reg == ST_RUN |=> !WP_IOIS16_PIN
	) else $error("write protect not low");

	chk_iois16: assert property (
		io_mode && PORT_16BIT |=> !WP_IOIS16_PIN
	) else $error("16-bit port not indicated");

	chk_iocs16: assert property (
		ide_reg && WORD_XFER_EXPECT |=> !WP_IOIS16_PIN
	) else $error("word cycle not indicated");
endmodule : cf_sig_ctrl

//--- hdl/cf_sig_pkg.sv
/*
 * constants, state types and timing counts for the card host-side
 * control and status signalling block.
 * assumes one 250 MHz system clock and an active-low async reset
 * that stands for power-up; pins are sampled through two flops.
 */
package cf_sig_pkg;
	// system clock period
	localparam int unsigned CLK_PERIOD_NS = 4;
	// initialization time after reset, least value
	localparam int unsigned INIT_TIME_NS = 1000;
	localparam int unsigned INIT_CYCLES =
		(INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// width of a pulse-mode interrupt strobe, least value
	localparam int unsigned IREQ_PULSE_NS = 500;
	localparam int unsigned IREQ_PULSE_CYCLES =
		(IREQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// width of the cycle timers
	localparam int unsigned TIMER_W = 16;
	// pin synchroniser: {mode, reset, reg_n, we_n, dmack_n}
	localparam int unsigned SYNC_W = 5;
	localparam logic [4:0] SYNC_RST = 5'h17;
	// settling cycles before the mode strap is taken
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	// output values during reset
	localparam logic RDY_RST = 1'h0;
	localparam logic WP_RST = 1'h1;
	localparam logic WAIT_N_RST = 1'h1;
	// sequencing of reset and initialization
	typedef enum {ST_STRAP, ST_HOLD, ST_INIT, ST_RUN} init_state_e;
endpackage : cf_sig_pkg

//--- hdl/cycle_timer.sv
/*
 * down-counting one-shot timer: busy for count cycles after start.
 * assumes start is a one-cycle pulse from the same clock.
 */
module cycle_timer #(
	parameter int unsigned W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	// cycles left
	logic [W-1:0] cnt_reg;

	// a start while running reloads the count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			done <= 1'h0;
		end else if (start) begin
			cnt_reg <= count;
			done <= 1'h0;
		end else begin
			done <= (cnt_reg == W'(1));
			if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - W'(1);
			end
		end
	end

	assign busy = (cnt_reg != '0);
endmodule : cycle_timer

//--- hdl/pin_sync.sv
/*
 * two-flop synchroniser for a group of independent pin levels.
 * assumes each bit is a slow level; bits are not coherent as a word.
 */
module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// first stage, read by the second stage only
	logic [W-1:0] meta_reg;

	// two flops per bit against metastability
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : pin_sync

//--- testbench/cf_sig_ctrl_tb.sv
/*
 * self-checking bench for the card signalling block, four scenarios:
 * memory mode with and without reset, I/O mode, true IDE mode.
 * assumes the host socket model drives every host pin.
 */
module cf_sig_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int INIT_T = 20; // shortened init, still above strap time
	localparam int PULSE_T = 2;
	logic clk, rst_n, core_busy, io_mode, irq_ev, irq_svc, irq_lvl, dma_en;
	logic dma_req, port16, word_exp;
	logic mode_sel, reset_pin, reg_n, we_n, dmack_n, rdy, wp, wait_n, dmarq;
	logic card_rst, init_done, mode_ide, mode_io, attr_sel, io_cycle;
	logic mem_stb, cfg_stb, dma_ack, irq_pend;
	int fails = 0, n_compared = 0, lo, mem, cfg, dack, wait_lo = 0, n;
	// 250 MHz system clock
	always #2 clk = ~clk;
	cf_sig_ctrl #(.INIT_CYC(INIT_T), .PULSE_CYC(PULSE_T)) u_cf_sig_ctrl (
		.CLK_SYS(clk), .RST_N(rst_n), .MODE_SEL_PIN(mode_sel),
		.RESET_PIN(reset_pin), .REG_N_PIN(reg_n), .WE_N_PIN(we_n),
		.DMACK_N_PIN(dmack_n), .CORE_BUSY(core_busy), .CORE_IO_MODE(io_mode),
		.IRQ_EVENT(irq_ev), .IRQ_SERVICED(irq_svc), .IRQ_LEVEL_MODE(irq_lvl),
		.DMA_ENABLE(dma_en), .DMA_REQ(dma_req), .PORT_16BIT(port16),
		.WORD_XFER_EXPECT(word_exp), .RDY_IRQ_PIN(rdy), .WP_IOIS16_PIN(wp),
		.WAIT_N_PIN(wait_n), .DMARQ_PIN(dmarq), .CARD_RESET(card_rst),
		.INIT_DONE(init_done), .MODE_IDE(mode_ide), .MODE_IO(mode_io),
		.ATTR_SEL(attr_sel), .IO_CYCLE(io_cycle), .MEM_WR_STROBE(mem_stb),
		.CFG_WR_STROBE(cfg_stb), .DMA_ACK(dma_ack), .IRQ_PENDING(irq_pend));
	host_socket u_host_socket (.clk(clk), .dmarq(dmarq), .mode_sel(mode_sel),
		.reset_pin(reset_pin), .reg_n(reg_n), .we_n(we_n), .dmack_n(dmack_n));
	// verdict and end of run
	task automatic test_done();
		if (fails == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
			fails++;
		end
	endtask : check_bit
	task automatic check_cnt(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
			fails++;
		end
	endtask : check_cnt
	// inputs change just after the edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	// run n cycles, counting low pin and strobe cycles
	task automatic run(input int k);
		lo = 0;
		mem = 0;
		cfg = 0;
		dack = 0;
		repeat (k) begin
			step();
			lo += int'(rdy === 1'h0);
			mem += int'(mem_stb === 1'h1);
			cfg += int'(cfg_stb === 1'h1);
			dack += int'(dma_ack === 1'h1);
			wait_lo += int'(wait_n !== 1'h1);
		end
	endtask : run
	function automatic logic probe(input int sel);
		case (sel)
			0: return rdy;
			1: return init_done;
			default: return dma_ack;
		endcase
	endfunction : probe
	// bounded wait; running out ends the run
	task automatic wait_for(input int sel, input logic exp, output int k);
		k = 0;
		while (probe(sel) !== exp) begin
			if (k == 300) begin
				fails++;
				test_done();
			end
			step();
			k++;
		end
	endtask : wait_for
	task automatic power_up(input logic ide, input logic rst_act);
		rst_n = 1'h0;
		u_host_socket.power(ide, rst_act);
		repeat (8) step();
		rst_n = 1'h1;
	endtask : power_up
	task automatic pulse_irq(input logic svc);
		if (svc) irq_svc = 1'h1;
		else irq_ev = 1'h1;
		step();
		irq_svc = 1'h0;
		irq_ev = 1'h0;
	endtask : pulse_irq
	// memory mode, powered up with reset pin inactive
	task automatic mem_no_reset();
		power_up(1'h0, 1'h0);
		wait_for(0, 1'h1, n);
		check_bit("fast_ready", 1'h1, n < INIT_T);
		core_busy = 1'h1;
		run(2);
		check_bit("busy_ready", 1'h0, rdy);
		core_busy = 1'h0;
		run(2);
		check_bit("idle_ready", 1'h1, rdy);
		u_host_socket.set_reg(1'h0);
		run(4);
		check_bit("attr_sel", 1'h1, attr_sel);
		u_host_socket.set_reg(1'h1);
		run(4);
		check_bit("common_sel", 1'h0, attr_sel);
		u_host_socket.write_cycle();
		run(6);
		check_cnt("mem_strobes", 1, mem);
		check_cnt("cfg_strobes", 0, cfg);
	endtask : mem_no_reset
	// memory mode, reset at power-up and again mid-run
	task automatic mem_reset();
		power_up(1'h0, 1'h1);
		run(10);
		check_bit("pwr_reset", 1'h1, card_rst);
		check_bit("pwr_ready", 1'h0, rdy);
		u_host_socket.host_reset(1'h0);
		wait_for(0, 1'h1, n);
		check_bit("init_len", 1'h1, n >= INIT_T);
		check_bit("wp_low", 1'h0, wp);
		check_bit("init_done", 1'h1, init_done);
		u_host_socket.host_reset(1'h1);
		run(5);
		check_bit("rst_ready", 1'h0, rdy);
		check_bit("rst_core", 1'h1, card_rst);
		u_host_socket.host_reset(1'h0);
		wait_for(0, 1'h1, n);
	endtask : mem_reset
	// I/O mode selects, strobes and interrupts
	task automatic io_mode_run();
		io_mode = 1'h1;
		run(3);
		check_bit("mode_io", 1'h1, mode_io);
		port16 = 1'h1;
		run(2);
		check_bit("io16_on", 1'h0, wp);
		port16 = 1'h0;
		run(2);
		check_bit("io16_off", 1'h1, wp);
		u_host_socket.set_reg(1'h0);
		run(4);
		check_bit("io_cycle", 1'h1, io_cycle);
		check_bit("io_attr", 1'h0, attr_sel);
		u_host_socket.set_reg(1'h1);
		u_host_socket.write_cycle();
		run(6);
		check_cnt("cfg_strobes", 1, cfg);
		check_cnt("mem_strobes", 0, mem);
		irq_lvl = 1'h1;
		pulse_irq(1'h0);
		run(6);
		check_bit("level_irq", 1'h0, rdy);
		check_bit("irq_pend", 1'h1, irq_pend);
		pulse_irq(1'h1);
		run(4);
		check_bit("irq_release", 1'h1, rdy);
		check_bit("irq_clear", 1'h0, irq_pend);
		irq_lvl = 1'h0;
		pulse_irq(1'h0);
		run(20);
		check_cnt("pulse_len", PULSE_T, lo);
		// still pending: a second event must not strobe again
		pulse_irq(1'h0);
		run(6);
		check_cnt("no_repulse", 0, lo);
		pulse_irq(1'h1);
		io_mode = 1'h0;
		run(3);
	endtask : io_mode_run
	// true IDE mode reset, interrupt, word cycle and DMA
	task automatic ide_run();
		power_up(1'h1, 1'h1);
		run(10);
		check_bit("ide_strap", 1'h1, mode_ide);
		check_bit("ide_reset", 1'h1, card_rst);
		u_host_socket.host_reset(1'h0);
		wait_for(1, 1'h1, n);
		check_bit("ide_init", 1'h1, n >= INIT_T);
		pulse_irq(1'h0);
		run(4);
		check_bit("intrq_high", 1'h1, rdy);
		pulse_irq(1'h1);
		run(4);
		check_bit("intrq_low", 1'h0, rdy);
		// raise and service in one cycle: the raise wins
		irq_ev = 1'h1;
		irq_svc = 1'h1;
		step();
		irq_ev = 1'h0;
		irq_svc = 1'h0;
		run(4);
		check_bit("set_wins", 1'h1, irq_pend);
		pulse_irq(1'h1);
		run(4);
		check_bit("set_clear", 1'h0, rdy);
		word_exp = 1'h1;
		run(2);
		check_bit("word_on", 1'h0, wp);
		word_exp = 1'h0;
		run(2);
		check_bit("word_off", 1'h1, wp);
		u_host_socket.dma_host = 1'h1;
		u_host_socket.ack_delay = 5;
		dma_en = 1'h1;
		dma_req = 1'h1;
		wait_for(2, 1'h1, n);
		check_bit("dma_request", 1'h1, dmarq);
		dma_req = 1'h0;
		run(6);
		check_bit("dma_release", 1'h0, dma_ack);
		// faulty acknowledge while DMA is off
		dma_en = 1'h0;
		dma_req = 1'h1;
		u_host_socket.force_ack = 1'h1;
		run(6);
		check_cnt("ignored_ack", 0, dack);
		check_bit("no_request", 1'h0, dmarq);
		u_host_socket.force_ack = 1'h0;
		dma_req = 1'h0;
	endtask : ide_run
	initial begin
		// quiet core inputs before the first power-up
		clk = 1'h0;
		rst_n = 1'h0;
		{core_busy, io_mode, irq_ev, irq_svc, irq_lvl} = 5'h00;
		{dma_en, dma_req, port16, word_exp} = 4'h0;
		mem_no_reset();
		mem_reset();
		io_mode_run();
		ide_run();
		check_cnt("wait_asserted", 0, wait_lo);
		test_done();
	end
endmodule : cf_sig_ctrl_tb

//--- testbench/host_socket.sv
/*
 * host socket model: drives the mode strap, reset, register select,
 * write strobe and DMA acknowledge pins of the card.
 * assumes the bench calls its tasks just after a rising clock edge.
 */
module host_socket (
	input wire logic clk,
	input wire logic dmarq,
	output logic mode_sel,
	output logic reset_pin,
	output logic reg_n,
	output logic we_n,
	output logic dmack_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ide; // host runs the card in true IDE mode
	logic dma_host; // host supports DMA at all
	logic force_ack; // faulty acknowledge, only on bench command
	int ack_delay; // slow or prompt answer to a request
	int req_age; // cycles the request has stood
	initial begin
		ide = 1'h0;
		dma_host = 1'h0;
		force_ack = 1'h0;
		ack_delay = 0;
		req_age = 0;
		mode_sel = 1'h1;
		reset_pin = 1'h0;
		reg_n = 1'h1;
		we_n = 1'h1;
		dmack_n = 1'h1;
	end
	task automatic power(input logic ide_m, input logic rst_act);
		ide = ide_m;
		mode_sel = ~ide_m;
		host_reset(rst_act);
	endtask : power
	task automatic host_reset(input logic act);
		reset_pin = ide ? ~act : act;
	endtask : host_reset
	task automatic set_reg(input logic v);
		reg_n = v;
	endtask : set_reg
	task automatic write_cycle();
		if (!ide) begin
			we_n = 1'h0;
			repeat (3) @(posedge clk);
			#1 we_n = 1'h1;
		end
	endtask : write_cycle
	always @(posedge clk) begin
		#1;
		req_age = dmarq ? req_age + 1 : 0;
		dmack_n = ~(force_ack | (dma_host & dmarq & (req_age > ack_delay)));
	end
endmodule : host_socket
